// File: brg_consts.svh
// Constants for the baud-rate generator: offsets, fields, reset values
`ifndef BRG_CONSTS_SVH
`define BRG_CONSTS_SVH
`define ADDR_MODE        12'h004
`define ADDR_DIVIDER     12'h020
`define ADDR_ETU         12'h040
`define ADDR_STATUS      12'h044
`define MODE_SRC_LSB     4
`define MODE_SRC_MSB     5
`define MODE_SYNC_BIT    8
`define MODE_PINOUT_BIT  18
`define MODE_OVER_BIT    19
`define MODE_SPEC_LSB    0
`define MODE_SPEC_MSB    3
`define DIV_WHOLE_MSB    15
`define DIV_FRAC_LSB     16
`define DIV_FRAC_MSB     18
`define ETU_MSB          10
`define ETU_RESET        11'h174
`define PRESCALE_DIV     3'h7
`define OVER16_LAST      4'hF
`define OVER8_LAST       4'h7
`define SRC_MAIN         2'h0
`define SRC_MAIN_DIV8    2'h1
`define SRC_PIN          2'h3
`define SPEC_NORMAL      4'h0
`define SPEC_CARD0       4'h4
`define SPEC_CARD1       4'h6
`endif

// File: brg_pkg.sv
// Types shared by the baud-rate generator
package brg_pkg;
	typedef struct packed {
		logic       sample_tick;
		logic       bit_tick;
		logic       etu_tick;
	} brg_ticks_type;

	typedef enum logic [1:0] {
		st_off    = 2'b00,
		st_reload = 2'b01,
		st_count  = 2'b11
	} div_state_type;
endpackage : brg_pkg

// File: baud_gen.sv
// Baud-rate generator with APB slave register access
//
// Chosen here: the placing of the registers and the APB slave port.
`include "brg_consts.svh"
module baud_gen
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Serial clock pin
	input  wire logic                   sck_in,
	output logic                        sck_out,
	output logic                        sck_oe,
	// Clock enables to receiver and transmitter
	output brg_pkg::brg_ticks_type      ticks
);
	// Registers
	logic [31:0] mode_register_ff;
	logic [18:0] baud_divider_register_ff;
	logic [10:0] etu_ratio_value_ff;

	// Field views
	logic [1:0]  clock_source_select;
	logic        clocked_link_select;
	logic        clock_output_enable;
	logic        sample_rate_select;
	logic [3:0]  spec_mode;
	logic [15:0] clock_divisor;
	logic [2:0]  fraction_part;
	logic        card_mode;
	assign clock_source_select = mode_register_ff[`MODE_SRC_MSB:`MODE_SRC_LSB];
	assign clocked_link_select = mode_register_ff[`MODE_SYNC_BIT];
	assign clock_output_enable = mode_register_ff[`MODE_PINOUT_BIT];
	assign sample_rate_select  = mode_register_ff[`MODE_OVER_BIT];
	assign spec_mode           = mode_register_ff[`MODE_SPEC_MSB:`MODE_SPEC_LSB];
	assign clock_divisor       = baud_divider_register_ff[`DIV_WHOLE_MSB:0];
	assign fraction_part       = baud_divider_register_ff[`DIV_FRAC_MSB:`DIV_FRAC_LSB];
	assign card_mode = (spec_mode == `SPEC_CARD0) || (spec_mode == `SPEC_CARD1);

	// APB decode; slave answers in the access cycle, zero wait states
	logic wr_en;
	logic addr_ok;
	assign wr_en   = psel && penable && pwrite;
	assign addr_ok = (paddr == `ADDR_MODE) || (paddr == `ADDR_DIVIDER)
		|| (paddr == `ADDR_ETU) || (paddr == `ADDR_STATUS);

	// Register writes
	// They land at the access edge, the same edge at which pready is sampled high
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_register_ff         <= 32'h0000_0000;
			baud_divider_register_ff <= 19'h0_0000;
			etu_ratio_value_ff       <= `ETU_RESET;
		end
		else if (wr_en)
		begin
			case (paddr)
				`ADDR_MODE:    mode_register_ff <= pwdata;
				`ADDR_DIVIDER: baud_divider_register_ff <= pwdata[`DIV_FRAC_MSB:0];
				`ADDR_ETU:     etu_ratio_value_ff <= pwdata[`ETU_MSB:0];
				default:       ;
			endcase
		end
	end

	// Pin synchroniser: first stage read only by the second
	// Reset to the pin's pulled-up idle level so no false edge follows reset
	logic sck_meta_ff;
	logic sck_sync_ff;
	logic sck_prev_ff;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sck_meta_ff <= 1'b1;
			sck_sync_ff <= 1'b1;
			sck_prev_ff <= 1'b1;
		end
		else
		begin
			sck_meta_ff <= sck_in;
			sck_sync_ff <= sck_meta_ff;
			sck_prev_ff <= sck_sync_ff;
		end
	end
	logic sck_rise;
	assign sck_rise = sck_sync_ff && !sck_prev_ff; // Needs pin phases over one period

	// Fixed divide-by-eight prescaler
	// Free-running, so its phase never depends on when software writes
	logic [2:0] pre_cnt_ff;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pre_cnt_ff <= 3'h0;
		else
			pre_cnt_ff <= pre_cnt_ff + 3'h1;
	end

	// Source selection as a one-cycle enable
	logic src_tick;
	always_comb
	begin
		case (clock_source_select)
			`SRC_MAIN:      src_tick = 1'b1;
			`SRC_MAIN_DIV8: src_tick = (pre_cnt_ff == `PRESCALE_DIV);
			`SRC_PIN:     src_tick = sck_rise;
			default:      src_tick = 1'b1;
		endcase
	end

	// Main divider; divisor and fraction are latched at reload, except divisor zero, which stops it at once
	brg_pkg::div_state_type state_ff;
	logic [15:0] div_cnt_ff;
	logic [15:0] cur_div_ff;
	logic [2:0]  frac_acc_ff;
	logic        frac_en;
	logic [3:0]  frac_sum;
	logic        extra_cycle;
	logic        extra_ff;
	assign frac_en  = (fraction_part != 3'h0) && (spec_mode == `SPEC_NORMAL)
		&& !clocked_link_select;
	assign frac_sum    = {1'b0, frac_acc_ff} + {1'b0, fraction_part};
	assign extra_cycle = frac_en && frac_sum[3];

	logic div_tick;
	assign div_tick = src_tick && (state_ff != brg_pkg::st_off) && (div_cnt_ff == 16'h0001)
		&& !extra_ff;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff    <= brg_pkg::st_off;
			div_cnt_ff  <= 16'h0000;
			cur_div_ff  <= 16'h0000;
			frac_acc_ff <= 3'h0;
			extra_ff    <= 1'b0;
		end
		else if (clock_divisor == 16'h0000)
		begin
			state_ff   <= brg_pkg::st_off; // No divider clock; only the pin ticks of sync_pin mode remain
			div_cnt_ff <= 16'h0000;
			extra_ff   <= 1'b0;
		end
		else if (state_ff == brg_pkg::st_off || (src_tick && div_cnt_ff == 16'h0001 && !extra_ff))
		begin
			// Reload: pick up new divisor and fraction here only
			state_ff    <= brg_pkg::st_reload;
			cur_div_ff  <= clock_divisor;
			div_cnt_ff  <= clock_divisor; // One reloads to one: divider bypassed
			frac_acc_ff <= frac_en ? frac_sum[2:0] : 3'h0;
			extra_ff    <= extra_cycle; // Stretch by one source cycle
		end
		else if (src_tick)
		begin
			state_ff <= brg_pkg::st_count;
			if (extra_ff)
				extra_ff <= 1'b0;
			else
				div_cnt_ff <= div_cnt_ff - 16'h0001;
		end
	end

	// Oversampling divider by 16 or 8, rate latched at its own wrap
	// A rate change mid-bit would otherwise give one short, corrupt bit period
	logic [3:0] over_cnt_ff;
	logic       over8_ff;
	logic [3:0] over_last;
	assign over_last = over8_ff ? `OVER8_LAST : `OVER16_LAST;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			over_cnt_ff <= 4'h0;
			over8_ff    <= 1'b0;
		end
		else if (div_tick)
		begin
			if (over_cnt_ff >= over_last)
			begin
				over_cnt_ff <= 4'h0;
				over8_ff    <= sample_rate_select;
			end
			else
				over_cnt_ff <= over_cnt_ff + 4'h1;
		end
	end

	// Smart-card sampling divider forms the bit time
	// Held at zero outside card mode so each card session starts a fresh bit
	logic [10:0] etu_cnt_ff;
	logic        etu_wrap;
	assign etu_wrap = (etu_cnt_ff >= etu_ratio_value_ff - 11'h001);
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			etu_cnt_ff <= 11'h000;
		else if (!card_mode || etu_ratio_value_ff == 11'h000)
			etu_cnt_ff <= 11'h000;
		else if (div_tick)
			etu_cnt_ff <= etu_wrap ? 11'h000 : etu_cnt_ff + 11'h001;
	end

	// Shared tick outputs
	logic sync_pin;
	logic nxt_bit;
	assign sync_pin = clocked_link_select && (clock_source_select == `SRC_PIN);
	always_comb
	begin
		if (sync_pin)
			nxt_bit = sck_rise; // Pin is the bit clock, divisor ignored
		else if (card_mode)
			nxt_bit = div_tick && etu_wrap && (etu_ratio_value_ff != 11'h000);
		else if (clocked_link_select)
			nxt_bit = div_tick;
		else
			nxt_bit = div_tick && (over_cnt_ff >= over_last);
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ticks <= '0;
		else
		begin
			ticks.sample_tick <= sync_pin ? sck_rise : div_tick;
			ticks.bit_tick    <= nxt_bit; // Same tick to rx and tx
			ticks.etu_tick    <= card_mode && nxt_bit;
		end
	end

	// Serial clock output: high for the first half of each divider period, divisor one aside.
	// An odd divisor above one cannot split into equal whole cycles with one clock
	// edge, so its high phase is one cycle longer; an exact 50:50 ratio
	// needs an even divisor or divisor one
	logic [16:0] half_pt;
	logic        nxt_sck;
	assign half_pt = {1'b0, cur_div_ff} >> 1;
	always_comb
	begin
		if (state_ff == brg_pkg::st_off)
			nxt_sck = 1'b0;
		else if (cur_div_ff == 16'h0001)
		begin
			// Bypassed: track the source as closely as one clock allows
			case (clock_source_select)
				`SRC_MAIN_DIV8: nxt_sck = pre_cnt_ff[2];
				`SRC_PIN:       nxt_sck = sck_sync_ff;
				default:        nxt_sck = ~sck_out;
			endcase
		end
		else
			nxt_sck = ({1'b0, div_cnt_ff} > half_pt); // Near 50:50
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sck_out <= 1'b0;
			sck_oe  <= 1'b0;
		end
		else
		begin
			sck_out <= nxt_sck;
			sck_oe  <= (card_mode && clock_output_enable)
				|| (clocked_link_select && !sync_pin && clock_output_enable);
		end
	end

	// APB read and answer
	// Data taken from the setup address, so it stands for the whole access cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			case (paddr)
				`ADDR_MODE:    prdata <= mode_register_ff;
				`ADDR_DIVIDER: prdata <= {13'h0000, baud_divider_register_ff};
				`ADDR_ETU:     prdata <= {21'h00_0000, etu_ratio_value_ff};
				`ADDR_STATUS:  prdata <= {27'h000_0000, frac_acc_ff, state_ff == brg_pkg::st_off,
					sck_sync_ff};
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : baud_gen

// File: brg_chk.sv
// Port checker for the baud-rate generator
`include "brg_consts.svh"
module brg_chk
(
	// Clock and reset
	input wire logic                   core_clk,
	input wire logic                   rst,
	// APB
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Pin and clock enables
	input wire logic                   sck_oe,
	input wire brg_pkg::brg_ticks_type ticks
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wr;
	logic div_set_ff;
	logic etu_ff;
	logic mode_ff;
	logic sync_ff;
	logic pinout_ff;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	assign wr = psel && penable && pready && pwrite;
	// Track what software has set; flags only, so no full register model is needed
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			{div_set_ff, etu_ff, mode_ff, sync_ff, pinout_ff} <= 5'h00;
		else if (wr)
		begin
			if (paddr == `ADDR_DIVIDER && pwdata[15:0] != 16'h0000)
				div_set_ff <= 1'b1;
			if (paddr == `ADDR_ETU)
				etu_ff <= 1'b1;
			if (paddr == `ADDR_MODE)
			begin
				mode_ff <= 1'b1;
				sync_ff <= pwdata[`MODE_SYNC_BIT];
				pinout_ff <= pwdata[`MODE_PINOUT_BIT];
			end
		end
	end
	sequence s_etu_read;
		pready && !pwrite && paddr == `ADDR_ETU && !etu_ff;
	endsequence
	property p_etu_reset;
		s_etu_read |-> prdata[10:0] == `ETU_RESET;
	endproperty
	a_etu_reset: assert property (p_etu_reset) else $error("ratio not at reset value");
	property p_idle;
		!div_set_ff && !mode_ff |-> ticks == 3'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("tick with divisor zero");
	property p_bit_pulse;
		!sync_ff && ticks.bit_tick |=> !ticks.bit_tick;
	endproperty
	a_bit_pulse: assert property (p_bit_pulse) else $error("bit tick too dense");
	property p_oe_off;
		!pinout_ff [*4] |-> !sck_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven without enable");
	property p_ready_access;
		pready |-> psel && penable;
	endproperty
	a_ready_access: assert property (p_ready_access) else $error("ready outside access");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready stood too long");
	property p_answer;
		psel && !penable |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no zero-wait answer");
	property p_err;
		pready |-> pslverr == !(paddr inside {`ADDR_MODE, `ADDR_DIVIDER, `ADDR_ETU, `ADDR_STATUS});
	endproperty
	a_err: assert property (p_err) else $error("error flag wrong for address");
endmodule : brg_chk
bind baud_gen brg_chk u_brg_chk (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sck_oe(sck_oe), .ticks(ticks));

// File: sck_src.sv
// Remote device driving the serial clock pin
module sck_src
(
	// Clock and control
	input wire logic core_clk,
	input wire logic run,
	// Serial clock pin
	output logic     sck_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	initial
	begin
		sck_in = 1'b1;
		cnt = 0;
	end
	// Five cycles per phase keeps the pin well below the master rate
	always @(posedge core_clk)
	begin
		cnt <= (!run || cnt == 4) ? 0 : cnt + 1;
		if (!run)
			sck_in <= 1'b1; // Rests at pull-up level outside frames
		else if (cnt == 4)
			sck_in <= !sck_in;
	end
endmodule : sck_src

// File: testbench.sv
// Self-checking bench for the baud-rate generator
`include "brg_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   core_clk;
	logic                   rst;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [11:0]            paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   sck_in;
	logic                   sck_out;
	logic                   sck_oe;
	logic                   run;
	brg_pkg::brg_ticks_type ticks;
	int                     fail_count;
	int                     n_checks;
	logic [31:0]            q;
	logic                   e;
	int                     c;
	baud_gen u_baud_gen (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .ticks(ticks));
	sck_src u_sck_src (.core_clk(core_clk), .run(run), .sck_in(sck_in));
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// One transfer; an idle edge follows so the next setup is a fresh assignment
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			fail_count++;
			close_out();
		end
		@(posedge core_clk);
	endtask : apb
	// Cycles over n intervals of tick s; two ticks skipped as old settings drain
	task automatic span(input int s, input int n);
		int k;
		k = 0;
		c = 0;
		for (int t = 0; t < 30000 && k < n + 3; t++)
		begin
			@(posedge core_clk);
			k += (ticks[s] === 1'b1);
			c += (k >= 3);
		end
		c = c - 1;
		if (k < n + 3)
		begin
			fail_count++;
			close_out();
		end
	endtask : span
	// High cycles of the serial clock drive over n cycles, left in c
	task automatic duty(input int n);
		c = 0;
		repeat (n)
		begin
			@(posedge core_clk);
			c += (sck_out === 1'b1);
		end
	endtask : duty
	task automatic t_reset();
		apb(1'b0, `ADDR_ETU, 32'h0);
		chk(q, 32'(`ETU_RESET));
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q[1], 1'b1);
		apb(1'b0, 12'h100, 32'h0);
		chk({e, q[30:0]}, 32'h8000_0000);
		$display("reset done");
	endtask : t_reset
	task automatic t_async();
		int tb[6][5] = '{'{0, 2, 1, 2, 64}, '{32'h0008_0000, 2, 1, 2, 32}, '{0, 1, 1, 2, 32},
			'{32'h0008_0010, 1, 1, 2, 128}, '{0, 3, 2, 4, 12},
			'{32'h0008_0000, 32'h0004_0002, 1, 4, 80}};
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, `ADDR_MODE, tb[i][0]);
			apb(1'b1, `ADDR_DIVIDER, tb[i][1]);
			span(tb[i][2], tb[i][3]);
			chk(c, tb[i][4]);
		end
		$display("async done");
	endtask : t_async
	// Fraction must be ignored here, else the bit time would stretch
	task automatic t_card();
		apb(1'b1, `ADDR_ETU, 32'h0000_0005);
		for (int m = 4; m < 8; m += 2)
		begin
			apb(1'b1, `ADDR_MODE, 32'h0004_0000 | m);
			span(0, 2);
			chk(c, 20);
			chk(sck_oe, 1'b1);
			duty(20);
			chk(c, 10);
		end
		$display("card done");
	endtask : t_card
	task automatic t_sync();
		apb(1'b1, `ADDR_DIVIDER, 32'h0000_0004);
		apb(1'b1, `ADDR_MODE, 32'h0000_0100);
		span(1, 4);
		chk(c, 16);
		duty(40);
		chk(c, 20);
		run <= 1'b1;
		apb(1'b1, `ADDR_MODE, 32'h0000_0130);
		span(1, 4);
		chk(c, 40);
		run <= 1'b0;
		apb(1'b1, `ADDR_DIVIDER, 32'hFFFF_FFFF);
		apb(1'b0, `ADDR_DIVIDER, 32'h0);
		chk(q[18:0], 32'h0007_FFFF);
		$display("sync done");
	endtask : t_sync
	// With mode cleared first, divisor zero must silence every tick and the serial clock output
	task automatic t_off();
		apb(1'b1, `ADDR_MODE, 32'h0000_0000);
		apb(1'b1, `ADDR_DIVIDER, 32'h0000_0000);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q[1], 1'b1);
		c = 0;
		repeat (64)
		begin
			@(posedge core_clk);
			c += (ticks !== 3'h0);
		end
		chk(c, 0);
		chk(sck_out, 1'b0);
		$display("off done");
	endtask : t_off
	initial
	begin
		{rst, psel, penable, pwrite, run} = 5'h10;
		paddr = 12'h000;
		pwdata = 32'h0;
		fail_count = 0;
		n_checks = 0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_async();
		t_card();
		t_sync();
		t_off();
		close_out();
	end
endmodule : testbench
